// ==== design/spib_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 10 MHz core clock
// Notes: channel n registers sit at n*16 plus the offsets below
`ifndef SPIB_CONSTS_SVH
`define SPIB_CONSTS_SVH

`define SPIB_CH_MAX 5
`define SPIB_OFF_CTRL 4'h0
`define SPIB_OFF_STAT 4'h4
`define SPIB_OFF_PORT 4'h8
`define SPIB_ADDR_MSTOP 8'h50

`define SPIB_CTRL_ERR_IE 0
`define SPIB_CTRL_RX_IE 1
`define SPIB_CTRL_TX_IE 2
`define SPIB_CTRL_TX_END_FLAG_IE 3
`define SPIB_CTRL_TX_EN 4
`define SPIB_CTRL_RE 5
`define SPIB_CTRL_SMART 6
`define SPIB_CTRL_BLOCK 7

`define SPIB_STAT_TX_EMPTY 0
`define SPIB_STAT_TX_END 1
`define SPIB_STAT_RX_FULL 2
`define SPIB_STAT_OVERRUN 3
`define SPIB_STAT_FRAMING 4
`define SPIB_STAT_PARITY 5
`define SPIB_STAT_ERR_SIG 6
`define SPIB_STAT_RXD 7

`define SPIB_PORT_DIR 0
`define SPIB_PORT_DATA 1
`define SPIB_PORT_SYNC 2

`define SPIB_CTRL_RST 8'h00
`define SPIB_PORT_RST 8'h00
`define SPIB_TX_EMPTY_RST 1'b1
`define SPIB_TX_END_RST 1'b1
`define SPIB_MSTOP_RST 1'b1

`define SPIB_CLK_PERIOD_NS 100
`define SPIB_BRK_TIME_NS 100000
`define SPIB_BRK_CYCLES ((`SPIB_BRK_TIME_NS + `SPIB_CLK_PERIOD_NS - 1) / `SPIB_CLK_PERIOD_NS)

`endif

// ==== design/spib_pkg.sv ====
// Purpose: shared types of the serial interrupt and break block
// Assumes: nothing
// Notes: source codes follow the default order inside a channel
package spib_pkg;
	typedef logic [7:0] spib_byte_type;
	typedef logic [7:0] spib_addr_type;
	typedef enum logic [1:0] {
		SRC_RX_ERROR = 2'b00,
		SRC_RX_FULL = 2'b01,
		SRC_TX_EMPTY = 2'b10,
		SRC_TX_END = 2'b11
	} spib_src_type;
endpackage

// ==== design/spib_brk.sv ====
// Purpose: receive pin synchroniser and break watch for one channel
// Assumes: pin is asynchronous to core_clk
// Notes: a break keeps pulsing while the line stays low
`timescale 1ns/1ps
`default_nettype none
module spib_brk
#(
	parameter int BRK_CYCLES = 1000
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic rxd_pin,
	input wire logic watch_en,
	output logic rx_level,
	output logic brk_pulse
);
	localparam int CW = $clog2(BRK_CYCLES + 1);
	logic meta_reg;
	logic sync_reg;
	logic [CW-1:0] low_cnt_reg;
	logic brk_reg;

	initial
	begin
		if (BRK_CYCLES < 2)
			$error("BRK_CYCLES too small");
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= rxd_pin;
			sync_reg <= meta_reg;
		end
	end

	// restart the count after each pulse so a held break sets framing again
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			low_cnt_reg <= '0;
			brk_reg <= 1'b0;
		end
		else if (!watch_en || sync_reg)
		begin
			low_cnt_reg <= '0;
			brk_reg <= 1'b0;
		end
		else if (low_cnt_reg == CW'(BRK_CYCLES - 1))
		begin
			low_cnt_reg <= '0;
			brk_reg <= 1'b1;
		end
		else
		begin
			low_cnt_reg <= low_cnt_reg + CW'(1);
			brk_reg <= 1'b0;
		end
	end

	assign rx_level = sync_reg;
	assign brk_pulse = brk_reg;
endmodule
`default_nettype wire

// ==== design/spib_top.sv ====
// Purpose: interrupt requests, transfer flag handling, break and mark control
// Assumes: serial core delivers one-cycle event pulses on core_clk
// Notes: registers read back one cycle after the read strobe
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spib_consts.svh"
//
// Operation
// - transmit empty flag raises its request
// - transmit end request needs flag and enable
// - receive full flag raises its request
// - normal mode: overrun, parity, framing raise error
// - every source has own vector and enable
// - only empty and full requests start transfers
// - transfer clears flag if enabled and count nonzero
// - transmit empty ranks before transmit end
// - clearing both flags leaves no end request
// - default order channel 0 up, error first
// - smart card mode never raises transmit end
// - smart card remaps empty and error sources
// - block transfer uses the normal mapping
// - reset leaves unit stopped, registers closed
// - low line sets framing again and again
// - receive pin level readable by software
// - transmit disabled: pin follows port registers
// - dropping transmit enable resets the transmitter
// - smart card error reply sets error signal flag
module spib_top
#(
	parameter int NCH = `SPIB_CH_MAX,
	parameter int BRK_CYCLES = `SPIB_BRK_CYCLES
)
(
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire spib_pkg::spib_addr_type ADDR,
	input wire spib_pkg::spib_byte_type WDATA,
	input wire logic WR,
	input wire logic RD,
	output spib_pkg::spib_byte_type RDATA,
	input wire logic [NCH-1:0] EV_TX_EMPTY,
	input wire logic [NCH-1:0] EV_TX_END,
	input wire logic [NCH-1:0] EV_RX_FULL,
	input wire logic [NCH-1:0] EV_OVERRUN,
	input wire logic [NCH-1:0] EV_FRAMING,
	input wire logic [NCH-1:0] EV_PARITY,
	input wire logic [NCH-1:0] EV_ERR_SIGNAL,
	input wire logic [NCH-1:0] TX_SERIAL,
	input wire logic [NCH-1:0] RXD,
	input wire logic [NCH-1:0] XFER_TX_ACK,
	input wire logic [NCH-1:0] XFER_RX_ACK,
	input wire logic [NCH-1:0] XFER_IRQ_SELECT,
	input wire logic [NCH-1:0] XFER_CNT_NZ,
	output logic [NCH-1:0] TX_EMPTY_IRQ,
	output logic [NCH-1:0] TX_END_IRQ,
	output logic [NCH-1:0] RX_FULL_IRQ,
	output logic [NCH-1:0] RX_ERROR_IRQ,
	output logic [NCH-1:0] XFER_TX_REQ,
	output logic [NCH-1:0] XFER_RX_REQ,
	output logic IRQ_TOP_VALID,
	output logic [4:0] IRQ_TOP_ID,
	output logic [NCH-1:0] TXD_O,
	output logic [NCH-1:0] TXD_OE,
	output logic [NCH-1:0] TX_INIT
);
	import spib_pkg::*;

	initial
	begin
		if (NCH < 1 || NCH > `SPIB_CH_MAX)
			$error("NCH out of range");
	end

	logic mstop_reg;
	spib_byte_type ctrl_reg [NCH];
	spib_byte_type port_reg [NCH];
	logic [NCH-1:0] tx_empty_reg;
	logic [NCH-1:0] tx_end_reg;
	logic [NCH-1:0] rx_full_reg;
	logic [NCH-1:0] overrun_reg;
	logic [NCH-1:0] framing_reg;
	logic [NCH-1:0] parity_reg;
	logic [NCH-1:0] err_sig_reg;
	logic [NCH-1:0] tx_en_d_reg;
	logic [NCH-1:0] txd_o_reg;
	logic [NCH-1:0] txd_oe_reg;
	logic [NCH-1:0] tx_init_reg;
	spib_byte_type rdata_reg;
	logic top_valid_reg;
	logic [4:0] top_id_reg;
	logic [NCH-1:0] rx_level;
	logic [NCH-1:0] brk_pulse;
	logic [NCH-1:0] watch_en;
	logic [NCH-1:0] smart;
	logic [NCH-1:0] tx_en;
	logic [NCH-1:0] re;
	logic [NCH-1:0] tx_clr_ok;
	logic [NCH-1:0] rx_clr_ok;
	logic [NCH-1:0] stat_wr;
	logic [2:0] ch_idx;
	logic [3:0] off;
	logic chan_hit;
	logic wr_ok;
	logic rd_ok;
	logic [4:0] top_id_next;
	logic top_valid_next;
	logic [4*NCH-1:0] pend;

	assign ch_idx = ADDR[6:4];
	assign off = ADDR[3:0];
	assign chan_hit = !ADDR[7] && ({1'b0, ch_idx} < 4'(NCH));
	// a stopped unit ignores channel accesses; only the stop bit answers
	assign wr_ok = WR && chan_hit && !mstop_reg;
	assign rd_ok = RD && chan_hit && !mstop_reg;

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			assign watch_en[g] = re[g] && !port_reg[g][`SPIB_PORT_SYNC];
			spib_brk #(.BRK_CYCLES(BRK_CYCLES)) u_brk
			(
				.core_clk(CORE_CLK),
				.arst_n(ARST_N),
				.rxd_pin(RXD[g]),
				.watch_en(watch_en[g]),
				.rx_level(rx_level[g]),
				.brk_pulse(brk_pulse[g])
			);
		end
	endgenerate

	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			tx_en[i] = ctrl_reg[i][`SPIB_CTRL_TX_EN];
			re[i] = ctrl_reg[i][`SPIB_CTRL_RE];
			smart[i] = ctrl_reg[i][`SPIB_CTRL_SMART] && !ctrl_reg[i][`SPIB_CTRL_BLOCK];
			stat_wr[i] = wr_ok && (ch_idx == 3'(i)) && (off == `SPIB_OFF_STAT);
			tx_clr_ok[i] = XFER_TX_ACK[i] && !XFER_IRQ_SELECT[i] && XFER_CNT_NZ[i];
			rx_clr_ok[i] = XFER_RX_ACK[i] && !XFER_IRQ_SELECT[i] && XFER_CNT_NZ[i];
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			mstop_reg <= `SPIB_MSTOP_RST;
		else if (WR && ADDR == `SPIB_ADDR_MSTOP)
			mstop_reg <= WDATA[0];
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				ctrl_reg[i] <= `SPIB_CTRL_RST;
				port_reg[i] <= `SPIB_PORT_RST;
			end
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (mstop_reg)
				begin
					ctrl_reg[i] <= `SPIB_CTRL_RST;
					port_reg[i] <= `SPIB_PORT_RST;
				end
				else if (wr_ok && ch_idx == 3'(i) && off == `SPIB_OFF_CTRL)
					ctrl_reg[i] <= WDATA;
				else if (wr_ok && ch_idx == 3'(i) && off == `SPIB_OFF_PORT)
					port_reg[i] <= WDATA;
			end
		end
	end

	// status bits clear by writing 0; a set event in the same cycle wins
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			tx_empty_reg <= {NCH{`SPIB_TX_EMPTY_RST}};
			tx_end_reg <= {NCH{`SPIB_TX_END_RST}};
			rx_full_reg <= '0;
			overrun_reg <= '0;
			framing_reg <= '0;
			parity_reg <= '0;
			err_sig_reg <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (mstop_reg)
				begin
					tx_empty_reg[i] <= `SPIB_TX_EMPTY_RST;
					tx_end_reg[i] <= `SPIB_TX_END_RST;
					rx_full_reg[i] <= 1'b0;
					overrun_reg[i] <= 1'b0;
					framing_reg[i] <= 1'b0;
					parity_reg[i] <= 1'b0;
					err_sig_reg[i] <= 1'b0;
				end
				else
				begin
					tx_empty_reg[i] <= EV_TX_EMPTY[i] || (tx_empty_reg[i]
						&& !(stat_wr[i] && !WDATA[`SPIB_STAT_TX_EMPTY])
						&& !tx_clr_ok[i]);
					// smart card transfers clear the end flag together with empty
					tx_end_reg[i] <= EV_TX_END[i] || (tx_end_reg[i]
						&& !(stat_wr[i] && !WDATA[`SPIB_STAT_TX_END])
						&& !(smart[i] && tx_clr_ok[i]));
					rx_full_reg[i] <= (EV_RX_FULL[i] && re[i]) || (rx_full_reg[i]
						&& !(stat_wr[i] && !WDATA[`SPIB_STAT_RX_FULL])
						&& !rx_clr_ok[i]);
					overrun_reg[i] <= (EV_OVERRUN[i] && re[i]) || (overrun_reg[i]
						&& !(stat_wr[i] && !WDATA[`SPIB_STAT_OVERRUN]));
					framing_reg[i] <= ((EV_FRAMING[i] && re[i]) || brk_pulse[i])
						|| (framing_reg[i]
						&& !(stat_wr[i] && !WDATA[`SPIB_STAT_FRAMING]));
					parity_reg[i] <= (EV_PARITY[i] && re[i]) || (parity_reg[i]
						&& !(stat_wr[i] && !WDATA[`SPIB_STAT_PARITY]));
					err_sig_reg[i] <= (EV_ERR_SIGNAL[i] && smart[i] && tx_en[i])
						|| (err_sig_reg[i]
						&& !(stat_wr[i] && !WDATA[`SPIB_STAT_ERR_SIG]));
				end
			end
		end
	end

	// request lines are levels straight from flags and enables
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			TX_EMPTY_IRQ[i] = ctrl_reg[i][`SPIB_CTRL_TX_IE]
				&& (smart[i] ? tx_end_reg[i] : tx_empty_reg[i]);
			TX_END_IRQ[i] = ctrl_reg[i][`SPIB_CTRL_TX_END_FLAG_IE] && tx_end_reg[i]
				&& !smart[i];
			RX_FULL_IRQ[i] = ctrl_reg[i][`SPIB_CTRL_RX_IE] && rx_full_reg[i];
			RX_ERROR_IRQ[i] = ctrl_reg[i][`SPIB_CTRL_ERR_IE] && (overrun_reg[i]
				|| parity_reg[i] || (smart[i] ? err_sig_reg[i] : framing_reg[i]));
			XFER_TX_REQ[i] = TX_EMPTY_IRQ[i];
			XFER_RX_REQ[i] = RX_FULL_IRQ[i];
			pend[4*i+0] = RX_ERROR_IRQ[i];
			pend[4*i+1] = RX_FULL_IRQ[i];
			pend[4*i+2] = TX_EMPTY_IRQ[i];
			pend[4*i+3] = TX_END_IRQ[i];
		end
	end

	// scan from the highest number down, so the lowest pending number and channel 0 receive error win
	always_comb
	begin
		top_valid_next = 1'b0;
		top_id_next = 5'h0;
		for (int k = 4 * NCH - 1; k >= 0; k--)
		begin
			if (pend[k])
			begin
				top_valid_next = 1'b1;
				top_id_next = 5'(k);
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			top_valid_reg <= 1'b0;
			top_id_reg <= 5'h0;
		end
		else
		begin
			top_valid_reg <= top_valid_next;
			top_id_reg <= top_id_next;
		end
	end

	// pin is registered so it never glitches while enable changes
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			tx_en_d_reg <= '0;
			txd_o_reg <= '0;
			txd_oe_reg <= '0;
			tx_init_reg <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				tx_en_d_reg[i] <= tx_en[i];
				tx_init_reg[i] <= tx_en_d_reg[i] && !tx_en[i];
				txd_o_reg[i] <= tx_en[i] ? TX_SERIAL[i] : port_reg[i][`SPIB_PORT_DATA];
				txd_oe_reg[i] <= tx_en[i] ? 1'b1 : port_reg[i][`SPIB_PORT_DIR];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			rdata_reg <= 8'h00;
		else if (RD && ADDR == `SPIB_ADDR_MSTOP)
			rdata_reg <= {7'h00, mstop_reg};
		else if (rd_ok && off == `SPIB_OFF_CTRL)
			rdata_reg <= ctrl_reg[ch_idx];
		else if (rd_ok && off == `SPIB_OFF_PORT)
			rdata_reg <= port_reg[ch_idx] & 8'h07;
		else if (rd_ok && off == `SPIB_OFF_STAT)
		begin
			rdata_reg[`SPIB_STAT_TX_EMPTY] <= tx_empty_reg[ch_idx];
			rdata_reg[`SPIB_STAT_TX_END] <= tx_end_reg[ch_idx];
			rdata_reg[`SPIB_STAT_RX_FULL] <= rx_full_reg[ch_idx];
			rdata_reg[`SPIB_STAT_OVERRUN] <= overrun_reg[ch_idx];
			rdata_reg[`SPIB_STAT_FRAMING] <= framing_reg[ch_idx];
			rdata_reg[`SPIB_STAT_PARITY] <= parity_reg[ch_idx];
			rdata_reg[`SPIB_STAT_ERR_SIG] <= err_sig_reg[ch_idx];
			rdata_reg[`SPIB_STAT_RXD] <= rx_level[ch_idx];
		end
		else
			rdata_reg <= 8'h00;
	end

	assign RDATA = rdata_reg;
	assign IRQ_TOP_VALID = top_valid_reg;
	assign IRQ_TOP_ID = top_id_reg;
	assign TXD_O = txd_o_reg;
	assign TXD_OE = txd_oe_reg;
	assign TX_INIT = tx_init_reg;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);

	a_txend_smart_off: assert property (smart[0] |-> !TX_END_IRQ[0])
		else $error("transmit end request in smart card mode");
	a_txempty_source: assert property (TX_EMPTY_IRQ[0] == (ctrl_reg[0][`SPIB_CTRL_TX_IE]
		&& (smart[0] ? tx_end_reg[0] : tx_empty_reg[0])))
		else $error("transmit empty request from wrong flag");
	a_rxerr_normal: assert property (!smart[0] && ctrl_reg[0][`SPIB_CTRL_ERR_IE]
		&& framing_reg[0] |-> RX_ERROR_IRQ[0])
		else $error("framing error gave no error request");
	a_xfer_tx_clear: assert property (tx_clr_ok[0] && !EV_TX_EMPTY[0] && !mstop_reg
		|=> !tx_empty_reg[0])
		else $error("transfer did not clear empty flag");
	a_xfer_tx_keep: assert property (XFER_TX_ACK[0] && !tx_clr_ok[0] && tx_empty_reg[0]
		&& !stat_wr[0] && !mstop_reg |=> tx_empty_reg[0])
		else $error("empty flag cleared without permission");
	a_xfer_no_err: assert property (XFER_TX_REQ == TX_EMPTY_IRQ && XFER_RX_REQ == RX_FULL_IRQ)
		else $error("transfer request from wrong source");
	a_stop_read_zero: assert property (mstop_reg && RD && chan_hit |=> RDATA == 8'h00)
		else $error("register readable while stopped");
	a_pin_port_mode: assert property (!tx_en[0] |=> TXD_OE[0] == $past(port_reg[0][`SPIB_PORT_DIR])
		&& TXD_O[0] == $past(port_reg[0][`SPIB_PORT_DATA]))
		else $error("transmit pin not following port bits");
	a_tx_drop_init: assert property ($fell(tx_en[0]) |=> TX_INIT[0] ##1 !TX_INIT[0])
		else $error("transmitter not initialised");
	a_prio_err_first: assert property (RX_ERROR_IRQ[0] |=> IRQ_TOP_VALID && IRQ_TOP_ID == 5'h00)
		else $error("channel 0 error not ranked first");
	a_err_sig_set: assert property (EV_ERR_SIGNAL[0] && smart[0] && tx_en[0] && !mstop_reg
		|=> err_sig_reg[0])
		else $error("error signal flag not set");
	a_break_refires: assert property (brk_pulse[0] && !mstop_reg |=> framing_reg[0])
		else $error("break did not set framing flag");
	a_rxd_readback: assert property (rd_ok && ch_idx == 3'h0 && off == `SPIB_OFF_STAT
		|=> RDATA[`SPIB_STAT_RXD] == $past(rx_level[0]))
		else $error("receive pin level not readable");

	c_xfer_clear: cover property (tx_clr_ok[0] ##1 !tx_empty_reg[0]);
	c_smart_tx: cover property (smart[0] && TX_EMPTY_IRQ[0]);
	c_break: cover property (brk_pulse[0] ##1 framing_reg[0]);
	c_tx_drop: cover property ($fell(tx_en[0]));
endmodule
`default_nettype wire

// ==== verification/spib_dtc_model.sv ====
// Purpose: transfer controller stand-in that answers channel requests
// Assumes: requests are levels, acks are one-cycle pulses
// Notes: answers after a set lag, so prompt and slow service are both seen
`timescale 1ns/1ps
`default_nettype none
module spib_xfer_model
#(
	parameter int NCH = 5
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [NCH-1:0] tx_req,
	input wire logic [NCH-1:0] rx_req,
	input wire logic shot,
	input wire logic [3:0] lag,
	input wire logic [1:0] cfg,
	output logic [NCH-1:0] tx_ack,
	output logic [NCH-1:0] rx_ack,
	output logic [NCH-1:0] xfer_irq_select,
	output logic [NCH-1:0] cnt_nz
);
	logic [4:0] wait_reg;
	// mode bits stand all the time, so they are valid beside every ack
	assign xfer_irq_select = {NCH{cfg[1]}};
	assign cnt_nz = {NCH{cfg[0]}};
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wait_reg <= 5'h00;
			tx_ack <= '0;
			rx_ack <= '0;
		end
		else
		begin
			tx_ack <= '0;
			rx_ack <= '0;
			if (shot)
				wait_reg <= {1'b0, lag} + 5'h01;
			else if (wait_reg == 5'h01)
			begin
				// only a pending empty or full request starts an access
				tx_ack <= tx_req;
				rx_ack <= rx_req;
				wait_reg <= 5'h00;
			end
			else if (wait_reg != 5'h00)
				wait_reg <= wait_reg - 5'h01;
		end
	end
endmodule
`default_nettype wire

// ==== verification/spib_top_tb_top.sv ====
// Purpose: self-checking bench for the serial interrupt and break block
// Assumes: short break count, transfer controller from spib_xfer_model
// Notes: events index 0 empty,1 end,2 full,3 overrun,4 framing,5 parity,6 err signal
`timescale 1ns/1ps
`default_nettype none
`define TB_CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module spib_top_tb_top;
	import spib_pkg::*;
	localparam int NCH = 5;
	localparam int BRK = 8;
	logic CORE_CLK = 1'b0;
	logic ARST_N = 1'b0;
	spib_addr_type ADDR = 8'h00;
	spib_byte_type WDATA = 8'h00;
	logic WR = 1'b0;
	logic RD = 1'b0;
	spib_byte_type RDATA;
	logic [NCH-1:0] ev [7] = '{default: '0};
	logic [NCH-1:0] TX_SERIAL = '1;
	logic [NCH-1:0] RXD = '1;
	logic shot = 1'b0;
	logic [3:0] lag = 4'h0;
	logic [1:0] cfg = 2'h0;
	logic [NCH-1:0] XFER_TX_ACK, XFER_RX_ACK, XFER_IRQ_SELECT, XFER_CNT_NZ;
	logic [NCH-1:0] TX_EMPTY_IRQ, TX_END_IRQ, RX_FULL_IRQ, RX_ERROR_IRQ;
	logic [NCH-1:0] XFER_TX_REQ, XFER_RX_REQ, TXD_O, TXD_OE, TX_INIT;
	logic IRQ_TOP_VALID;
	logic [4:0] IRQ_TOP_ID;
	int bad_count = 0;
	int checked = 0;

	always #50 CORE_CLK = ~CORE_CLK;

	spib_top #(.NCH(NCH), .BRK_CYCLES(BRK)) spib_top_i (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EV_TX_EMPTY(ev[0]),
		.EV_TX_END(ev[1]), .EV_RX_FULL(ev[2]), .EV_OVERRUN(ev[3]), .EV_FRAMING(ev[4]),
		.EV_PARITY(ev[5]), .EV_ERR_SIGNAL(ev[6]), .TX_SERIAL(TX_SERIAL), .RXD(RXD),
		.XFER_TX_ACK(XFER_TX_ACK), .XFER_RX_ACK(XFER_RX_ACK), .XFER_IRQ_SELECT(XFER_IRQ_SELECT),
		.XFER_CNT_NZ(XFER_CNT_NZ), .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .TX_END_IRQ(TX_END_IRQ),
		.RX_FULL_IRQ(RX_FULL_IRQ), .RX_ERROR_IRQ(RX_ERROR_IRQ), .XFER_TX_REQ(XFER_TX_REQ),
		.XFER_RX_REQ(XFER_RX_REQ), .IRQ_TOP_VALID(IRQ_TOP_VALID), .IRQ_TOP_ID(IRQ_TOP_ID),
		.TXD_O(TXD_O), .TXD_OE(TXD_OE), .TX_INIT(TX_INIT));

	spib_xfer_model #(.NCH(NCH)) spib_xfer_model_i (.clk(CORE_CLK), .arst_n(ARST_N),
		.tx_req(XFER_TX_REQ), .rx_req(XFER_RX_REQ), .shot(shot), .lag(lag), .cfg(cfg),
		.tx_ack(XFER_TX_ACK), .rx_ack(XFER_RX_ACK), .xfer_irq_select(XFER_IRQ_SELECT),
		.cnt_nz(XFER_CNT_NZ));

	task automatic wr(input spib_addr_type a, input spib_byte_type d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rd(input spib_addr_type a, output spib_byte_type d);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		@(negedge CORE_CLK);
		d = RDATA;
	endtask

	task automatic pulse(input int k, input logic [NCH-1:0] m);
		@(posedge CORE_CLK);
		ev[k] <= m;
		@(posedge CORE_CLK);
		ev[k] <= '0;
		@(negedge CORE_CLK);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge CORE_CLK);
	endtask

	task automatic wrap_up();
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#(20000 * 100);
		bad_count++;
		wrap_up();
	end

	initial
	begin
		spib_byte_type d;
		logic [3:0] n;
		repeat (20) @(posedge CORE_CLK);
		ARST_N <= 1'b1;
		wr(8'h00, 8'h1F);
		rd(8'h04, d); `TB_CHK(d, 8'h00)
		wr(8'h50, 8'h00);
		rd(8'h00, d); `TB_CHK(d, 8'h00)
		rd(8'h04, d); `TB_CHK(d, 8'h83)
		wr(8'h00, 8'h0F);
		cyc(2);
		`TB_CHK(TX_EMPTY_IRQ, 5'h01)
		`TB_CHK(TX_END_IRQ, 5'h01)
		`TB_CHK(XFER_TX_REQ, 5'h01)
		`TB_CHK(IRQ_TOP_ID, 5'h02)
		wr(8'h00, 8'h07);
		cyc(1);
		`TB_CHK(TX_END_IRQ[0], 1'b0)
		wr(8'h00, 8'h0B);
		cyc(2);
		`TB_CHK({TX_EMPTY_IRQ[0], XFER_TX_REQ[0]}, 2'b00)
		`TB_CHK(IRQ_TOP_ID, 5'h03)
		wr(8'h04, 8'h00);
		cyc(2);
		`TB_CHK({TX_END_IRQ[0], IRQ_TOP_VALID}, 2'b00)
		wr(8'h00, 8'h23);
		pulse(2, 5'h01);
		`TB_CHK({RX_FULL_IRQ, XFER_RX_REQ}, 10'h021)
		for (int i = 3; i < 6; i++)
		begin
			pulse(i, 5'h01);
			`TB_CHK(RX_ERROR_IRQ, 5'h01)
			`TB_CHK(XFER_RX_REQ, 5'h01)
			cyc(1);
			`TB_CHK(IRQ_TOP_ID, 5'h00)
			wr(8'h04, 8'h04);
			cyc(1);
			`TB_CHK(RX_ERROR_IRQ, 5'h00)
		end
		wr(8'h10, 8'h21);
		pulse(3, 5'h02);
		`TB_CHK(RX_ERROR_IRQ, 5'h02)
		cyc(1);
		`TB_CHK(IRQ_TOP_ID, 5'h01)
		wr(8'h04, 8'h00);
		cyc(2);
		`TB_CHK(IRQ_TOP_ID, 5'h04)
		wr(8'h10, 8'h00);
		wr(8'h00, 8'h26);
		for (int i = 0; i < 4; i++)
		begin
			pulse(0, 5'h01);
			pulse(2, 5'h01);
			@(posedge CORE_CLK);
			cfg <= 2'(i);
			lag <= 4'(i);
			shot <= 1'b1;
			@(posedge CORE_CLK);
			shot <= 1'b0;
			cyc(i + 4);
			`TB_CHK(TX_EMPTY_IRQ[0], i != 1)
			`TB_CHK(RX_FULL_IRQ[0], i != 1)
		end
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h7F);
		pulse(0, 5'h01);
		`TB_CHK(TX_EMPTY_IRQ[0], 1'b0)
		pulse(1, 5'h01);
		`TB_CHK({TX_EMPTY_IRQ[0], TX_END_IRQ[0]}, 2'b10)
		pulse(4, 5'h01);
		`TB_CHK(RX_ERROR_IRQ[0], 1'b0)
		pulse(6, 5'h01);
		`TB_CHK(RX_ERROR_IRQ[0], 1'b1)
		rd(8'h04, d); `TB_CHK(d[6], 1'b1)
		wr(8'h00, 8'hFF);
		cyc(1);
		`TB_CHK({TX_EMPTY_IRQ[0], TX_END_IRQ[0]}, 2'b11)
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h21);
		@(posedge CORE_CLK);
		RXD <= 5'h1E;
		cyc(BRK + 4);
		`TB_CHK(RX_ERROR_IRQ[0], 1'b1)
		rd(8'h04, d); `TB_CHK({d[7], d[4]}, 2'b01)
		wr(8'h04, 8'h00);
		cyc(BRK + 2);
		`TB_CHK(RX_ERROR_IRQ[0], 1'b1)
		@(posedge CORE_CLK);
		RXD <= '1;
		wr(8'h00, 8'h00);
		wr(8'h08, 8'h01);
		cyc(2);
		`TB_CHK({TXD_OE[0], TXD_O[0]}, 2'b10)
		wr(8'h08, 8'h03);
		cyc(2);
		`TB_CHK({TXD_OE[0], TXD_O[0]}, 2'b11)
		wr(8'h08, 8'h02);
		cyc(2);
		`TB_CHK(TXD_OE[0], 1'b0)
		wr(8'h00, 8'h10);
		wr(8'h08, 8'h01);
		cyc(2);
		`TB_CHK({TXD_OE[0], TXD_O[0]}, 2'b11)
		wr(8'h00, 8'h00);
		n = 4'h0;
		repeat (4)
		begin
			@(negedge CORE_CLK);
			n = n + {3'h0, TX_INIT[0]};
		end
		`TB_CHK(n, 4'h1)
		`TB_CHK({TXD_OE[0], TXD_O[0]}, 2'b10)
		wr(8'h50, 8'h01);
		rd(8'h08, d); `TB_CHK(d, 8'h00)
		wrap_up();
	end
endmodule
`default_nettype wire
